// File: common/gpio_port_defines.vh
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH

// port width
`define PORT_WIDTH       8

// configuration select codes on cfgSelect
`define CFG_SEL_WIDTH    4
`define CFG_DIRECTION    4'h0
`define CFG_IRQ_SENSE    4'h1
`define CFG_IRQ_BOTH     4'h2
`define CFG_IRQ_EVENT    4'h3
`define CFG_IRQ_MASK     4'h4
`define CFG_ALT_FUNC     4'h5
`define CFG_DRIVE_2MA    4'h6
`define CFG_DRIVE_4MA    4'h7
`define CFG_DRIVE_8MA    4'h8
`define CFG_OPEN_DRAIN   4'h9
`define CFG_PULL_UP      4'hA
`define CFG_PULL_DOWN    4'hB
`define CFG_SLEW_LIMIT   4'hC
`define CFG_DIGITAL_EN   4'hD

// reset values
`define RST_ZERO         8'h00
`define RST_DRIVE_2MA    8'hFF
`define RST_PULL_UP      8'hFF
`define RST_DIGITAL_EN   8'hFF
`define RST_ALT_FUNC     8'h00
`define ALL_PINS         8'hFF

// identification words, index 0..11; values are arbitrary
`define ID_INDEX_WIDTH   4
`define ID_COUNT         12
`define ID_WORD_0        8'h00
`define ID_WORD_1        8'h00
`define ID_WORD_2        8'h00
`define ID_WORD_3        8'h00
`define ID_WORD_4        8'h5A
`define ID_WORD_5        8'h01
`define ID_WORD_6        8'h20
`define ID_WORD_7        8'h03
`define ID_WORD_8        8'h0C
`define ID_WORD_9        8'hA0
`define ID_WORD_10       8'h07
`define ID_WORD_11       8'hC3

`endif

// File: hdl/general_purpose_io_port.v
`timescale 1ns/10ps
`include "gpio_port_defines.vh"

//Contract
//- direction zero makes a pin input; data bit captures the sampled pad.
//- direction one makes a pin output; data bit drives the pad.
//- data register has 256 addresses; address bits 9:2 mask each access.
//- data write changes only bits whose address mask bit is one.
//- data read returns masked bits, zero where mask bit is zero.
//- all pin interrupts merge into one interrupt output.
//- edge interrupt stays latched until software clears it.
//- sense bit zero selects edge, one selects level detection.
//- in edge mode, both-edges bit one detects either edge and ignores event bit.
//- event bit zero means low or falling, one means high or rising.
//- mask bit zero blocks the pin interrupt, one passes it.
//- raw status sets on trigger condition regardless of mask.
//- masked status is raw status and mask bit together.
//- writing one to clear bit clears latched interrupt; zero does nothing.
//- alternate select one hands the pin to its peripheral.
//- alternate select zero keeps pin under data and direction control.
//- reset makes pins inputs, alternate off except the debug pins.
//- any reset returns every pin, debug pins too, to defaults.
//- per-pin drive 2/4/8 mA, open drain, pulls, input enable, slew.
//- read-only identification words fixed at reset identify the block.
//- data read gives written value for outputs, pad value for inputs.
//- unconnected bits ignore writes; data and status read zero, config bits keep their reset value.
module general_purpose_io_port #(
	parameter [7:0] PIN_PRESENT  = `ALL_PINS,
	parameter [7:0] ALT_FUNC_RST = `RST_ALT_FUNC
) (
	// clock and reset
	input  wire       clk,
	input  wire       arst_n,
	// data register access
	input  wire       dataWrite,
	input  wire       dataRead,
	input  wire [7:0] dataAddrMask,
	input  wire [7:0] dataWrData,
	output reg  [7:0] dataRdData_reg,
	// configuration writes
	input  wire       cfgWrite,
	input  wire [3:0] cfgSelect,
	input  wire [7:0] cfgWrData,
	// interrupt clear and status
	input  wire [7:0] irqClearBits,
	output reg  [7:0] irqRawStatus_reg,
	output reg  [7:0] irqMaskedStatus_reg,
	output reg        irqOut_reg,
	// configuration readback
	output reg  [7:0] pinDirectionBits_reg,
	output reg  [7:0] irqSenseSelect_reg,
	output reg  [7:0] irqBothEdgesSelect_reg,
	output reg  [7:0] irqEventPolarity_reg,
	output reg  [7:0] irqMaskBits_reg,
	output reg  [7:0] altFunctionSelect_reg,
	// pad controls
	output reg  [7:0] drive2maSelect_reg,
	output reg  [7:0] drive4maSelect_reg,
	output reg  [7:0] drive8maSelect_reg,
	output reg  [7:0] openDrainSelect_reg,
	output reg  [7:0] pullUpSelect_reg,
	output reg  [7:0] pullDownSelect_reg,
	output reg  [7:0] slewLimitSelect_reg,
	output reg  [7:0] digitalInputEnable_reg,
	// pads
	input  wire [7:0] padIn,
	output reg  [7:0] padOut_reg,
	output reg  [7:0] padOeN_reg,
	// alternate-function peripherals
	input  wire [7:0] altOut,
	input  wire [7:0] altOe,
	output reg  [7:0] altIn_reg,
	// identification
	input  wire [3:0] identIndex,
	output reg  [7:0] identWord_reg
);

	function [7:0] writeMerge;
		input [7:0] oldValue;
		input [7:0] newValue;
		input [7:0] mask;
		begin
			writeMerge = (oldValue & ~(mask & PIN_PRESENT)) |
				(newValue & mask & PIN_PRESENT);
		end
	endfunction

	function [7:0] identLookup;
		input [3:0] index;
		begin
			case (index)
				4'h0: identLookup = `ID_WORD_0;
				4'h1: identLookup = `ID_WORD_1;
				4'h2: identLookup = `ID_WORD_2;
				4'h3: identLookup = `ID_WORD_3;
				4'h4: identLookup = `ID_WORD_4;
				4'h5: identLookup = `ID_WORD_5;
				4'h6: identLookup = `ID_WORD_6;
				4'h7: identLookup = `ID_WORD_7;
				4'h8: identLookup = `ID_WORD_8;
				4'h9: identLookup = `ID_WORD_9;
				4'hA: identLookup = `ID_WORD_10;
				4'hB: identLookup = `ID_WORD_11;
				default: identLookup = `RST_ZERO;
			endcase
		end
	endfunction

	reg  [7:0] syncFirst_reg;
	reg  [7:0] syncSecond_reg;
	reg  [7:0] syncPrev_reg;
	reg  [7:0] dataValue_reg;
	reg  [7:0] dataValue_next;
	reg  [7:0] irqRaw_next;
	wire [7:0] trigger;
	wire [7:0] sampledIn;
	wire [7:0] cfgMask;

	// input sampling gated by digital input enable
	assign sampledIn = syncSecond_reg & digitalInputEnable_reg;
	assign cfgMask = cfgWrite ? `ALL_PINS : `RST_ZERO;

	genvar i;
	generate
		for (i = 0; i < `PORT_WIDTH; i = i + 1) begin : gTrig
			wire curr = sampledIn[i];
			wire prev = syncPrev_reg[i] & digitalInputEnable_reg[i];
			wire lvl  = irqEventPolarity_reg[i] ? curr : ~curr;
			wire rise = curr & ~prev;
			wire fall = ~curr & prev;
			wire edg  = irqBothEdgesSelect_reg[i] ? (rise | fall) :
				(irqEventPolarity_reg[i] ? rise : fall);
			assign trigger[i] = PIN_PRESENT[i] &
				(irqSenseSelect_reg[i] ? lvl : edg);
		end
	endgenerate

	always @* begin
		// inputs follow pad, outputs take masked writes
		dataValue_next = writeMerge(dataValue_reg, dataWrData,
			dataWrite ? dataAddrMask : `RST_ZERO);
		dataValue_next = (dataValue_next & pinDirectionBits_reg) |
			(sampledIn & ~pinDirectionBits_reg & PIN_PRESENT);
		// set wins over clear; latched until cleared
		irqRaw_next = (irqRawStatus_reg & ~irqClearBits) |
			trigger;
	end

	// synchroniser and edge history
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			syncFirst_reg  <= `RST_ZERO;
			syncSecond_reg <= `RST_ZERO;
			syncPrev_reg   <= `RST_ZERO;
		end else begin
			syncFirst_reg  <= padIn;
			syncSecond_reg <= syncFirst_reg;
			syncPrev_reg   <= syncSecond_reg;
		end
	end

	// data register
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dataValue_reg <= `RST_ZERO;
		end else begin
			dataValue_reg <= dataValue_next;
		end
	end

	// masked read; result holds until the next read
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dataRdData_reg <= `RST_ZERO;
		end else if (dataRead) begin
			dataRdData_reg <= dataValue_reg & dataAddrMask &
				PIN_PRESENT;
		end
	end

	// interrupt status and port interrupt
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqRawStatus_reg    <= `RST_ZERO;
			irqMaskedStatus_reg <= `RST_ZERO;
			irqOut_reg          <= 1'b0;
		end else begin
			irqRawStatus_reg    <= irqRaw_next;
			irqMaskedStatus_reg <= irqRaw_next & irqMaskBits_reg;
			irqOut_reg <= |(irqRaw_next & irqMaskBits_reg);
		end
	end

	// peripheral input and identification readback
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			altIn_reg     <= `RST_ZERO;
			identWord_reg <= `RST_ZERO;
		end else begin
			altIn_reg     <= sampledIn & altFunctionSelect_reg;
			identWord_reg <= identLookup(identIndex);
		end
	end

	// pad drive: alternate function or software control
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			padOut_reg <= `RST_ZERO;
			padOeN_reg <= `ALL_PINS;
		end else begin
			padOut_reg <= PIN_PRESENT & ~openDrainSelect_reg &
				((altFunctionSelect_reg & altOut) |
				(~altFunctionSelect_reg & dataValue_next));
			padOeN_reg <= ~(PIN_PRESENT &
				((altFunctionSelect_reg & altOe) |
				(~altFunctionSelect_reg & pinDirectionBits_reg)) &
				(~openDrainSelect_reg |
				~((altFunctionSelect_reg & altOut) |
				(~altFunctionSelect_reg & dataValue_next))));
		end
	end

	// configuration registers
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pinDirectionBits_reg   <= `RST_ZERO;
			irqSenseSelect_reg     <= `RST_ZERO;
			irqBothEdgesSelect_reg <= `RST_ZERO;
			irqEventPolarity_reg   <= `RST_ZERO;
			irqMaskBits_reg        <= `RST_ZERO;
			altFunctionSelect_reg  <= ALT_FUNC_RST;
			drive2maSelect_reg     <= `RST_DRIVE_2MA;
			drive4maSelect_reg     <= `RST_ZERO;
			drive8maSelect_reg     <= `RST_ZERO;
			openDrainSelect_reg    <= `RST_ZERO;
			pullUpSelect_reg       <= `RST_PULL_UP;
			pullDownSelect_reg     <= `RST_ZERO;
			slewLimitSelect_reg    <= `RST_ZERO;
			digitalInputEnable_reg <= `RST_DIGITAL_EN;
		end else if (cfgWrite) begin
			case (cfgSelect)
				`CFG_DIRECTION: begin
					pinDirectionBits_reg <=
						writeMerge(pinDirectionBits_reg, cfgWrData, cfgMask);
				end
				`CFG_IRQ_SENSE: begin
					irqSenseSelect_reg <=
						writeMerge(irqSenseSelect_reg, cfgWrData, cfgMask);
				end
				`CFG_IRQ_BOTH: begin
					irqBothEdgesSelect_reg <=
						writeMerge(irqBothEdgesSelect_reg, cfgWrData, cfgMask);
				end
				`CFG_IRQ_EVENT: begin
					irqEventPolarity_reg <=
						writeMerge(irqEventPolarity_reg, cfgWrData, cfgMask);
				end
				`CFG_IRQ_MASK: begin
					irqMaskBits_reg <=
						writeMerge(irqMaskBits_reg, cfgWrData, cfgMask);
				end
				`CFG_ALT_FUNC: begin
					altFunctionSelect_reg <=
						writeMerge(altFunctionSelect_reg, cfgWrData, cfgMask);
				end
				`CFG_DRIVE_2MA: begin
					drive2maSelect_reg <=
						writeMerge(drive2maSelect_reg, cfgWrData, cfgMask);
				end
				`CFG_DRIVE_4MA: begin
					drive4maSelect_reg <=
						writeMerge(drive4maSelect_reg, cfgWrData, cfgMask);
				end
				`CFG_DRIVE_8MA: begin
					drive8maSelect_reg <=
						writeMerge(drive8maSelect_reg, cfgWrData, cfgMask);
				end
				`CFG_OPEN_DRAIN: begin
					openDrainSelect_reg <=
						writeMerge(openDrainSelect_reg, cfgWrData, cfgMask);
				end
				`CFG_PULL_UP: begin
					pullUpSelect_reg <=
						writeMerge(pullUpSelect_reg, cfgWrData, cfgMask);
				end
				`CFG_PULL_DOWN: begin
					pullDownSelect_reg <=
						writeMerge(pullDownSelect_reg, cfgWrData, cfgMask);
				end
				`CFG_SLEW_LIMIT: begin
					slewLimitSelect_reg <=
						writeMerge(slewLimitSelect_reg, cfgWrData, cfgMask);
				end
				`CFG_DIGITAL_EN: begin
					digitalInputEnable_reg <=
						writeMerge(digitalInputEnable_reg, cfgWrData, cfgMask);
				end
				default: ;
			endcase
		end
	end

endmodule // general_purpose_io_port

// File: test/general_purpose_io_port_bench.sv
`timescale 1ns/10ps
`include "gpio_port_defines.vh"
module general_purpose_io_port_bench;
	localparam [14:0]  MODES = 15'b100_101_010_000_001;
	localparam [111:0] RST_VIEW = 112'hFF00_00FF_0000_00FF_0000_0000_0000;
	localparam [7:0]   DBG_PRESENT = 8'h7F;
	localparam [7:0]   DBG_ALT_RST = 8'h80;
	localparam [95:0]  ID_VIEW = {`ID_WORD_11, `ID_WORD_10, `ID_WORD_9,
		`ID_WORD_8, `ID_WORD_7, `ID_WORD_6, `ID_WORD_5, `ID_WORD_4,
		`ID_WORD_3, `ID_WORD_2, `ID_WORD_1, `ID_WORD_0};
	reg        clk = 0, arst_n = 0, dataWrite = 0, dataRead = 0, cfgWrite = 0;
	reg  [7:0] dataAddrMask = 0, dataWrData = 0, cfgWrData = 0, altOut = 0;
	reg  [7:0] altOe = 0, extLevel = 0, irqClearBits = 0;
	reg  [3:0] cfgSelect = 0, identIndex = 0;
	reg  [7:0] m, exp, a, b, c;
	reg  [2:0] md;
	integer    errors = 0, nTests = 0, cycles = 0, i, s;
	wire [7:0] padIn, dataRdData_reg, irqRawStatus_reg, irqMaskedStatus_reg;
	wire [7:0] pinDirectionBits_reg, irqSenseSelect_reg, irqBothEdgesSelect_reg;
	wire [7:0] irqEventPolarity_reg, irqMaskBits_reg, altFunctionSelect_reg;
	wire [7:0] drive2maSelect_reg, drive4maSelect_reg, drive8maSelect_reg;
	wire [7:0] openDrainSelect_reg, pullUpSelect_reg, pullDownSelect_reg;
	wire [7:0] slewLimitSelect_reg, digitalInputEnable_reg, padOut_reg;
	wire [7:0] padOeN_reg, altIn_reg, identWord_reg;
	wire       irqOut_reg;
	wire [7:0] dbgRdData, dbgAltSelect;
	wire [111:0] cfgView = {digitalInputEnable_reg, slewLimitSelect_reg,
		pullDownSelect_reg, pullUpSelect_reg, openDrainSelect_reg,
		drive8maSelect_reg, drive4maSelect_reg, drive2maSelect_reg,
		altFunctionSelect_reg, irqMaskBits_reg, irqEventPolarity_reg,
		irqBothEdgesSelect_reg, irqSenseSelect_reg, pinDirectionBits_reg};
	general_purpose_io_port i_dut (.*);
	pad_model i_pads (.padOut(padOut_reg), .padOeN(padOeN_reg),
		.extLevel(extLevel), .padIn(padIn));
	// port with one absent pin and one debug pin
	general_purpose_io_port #(
		.PIN_PRESENT  (DBG_PRESENT),
		.ALT_FUNC_RST (DBG_ALT_RST)
	) i_dbg (
		.clk(clk), .arst_n(arst_n), .dataWrite(dataWrite),
		.dataRead(dataRead), .dataAddrMask(dataAddrMask),
		.dataWrData(dataWrData), .dataRdData_reg(dbgRdData),
		.cfgWrite(cfgWrite), .cfgSelect(cfgSelect),
		.cfgWrData(cfgWrData), .irqClearBits(irqClearBits),
		.irqRawStatus_reg(), .irqMaskedStatus_reg(), .irqOut_reg(),
		.pinDirectionBits_reg(), .irqSenseSelect_reg(),
		.irqBothEdgesSelect_reg(), .irqEventPolarity_reg(),
		.irqMaskBits_reg(), .altFunctionSelect_reg(dbgAltSelect),
		.drive2maSelect_reg(), .drive4maSelect_reg(),
		.drive8maSelect_reg(), .openDrainSelect_reg(),
		.pullUpSelect_reg(), .pullDownSelect_reg(),
		.slewLimitSelect_reg(), .digitalInputEnable_reg(),
		.padIn(padIn), .padOut_reg(), .padOeN_reg(),
		.altOut(altOut), .altOe(altOe), .altIn_reg(),
		.identIndex(identIndex), .identWord_reg());
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors = errors + 1;
			finish_test;
		end
	end
	task check(input string name, input [7:0] seen, input [7:0] want);
		nTests = nTests + 1;
		if (seen !== want) begin
			errors = errors + 1;
			$display("[FAIL] %s expected %h seen %h", name, want, seen);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task cfg(input [3:0] sel, input [7:0] d);
		cfgWrite = 1;
		cfgSelect = sel;
		cfgWrData = d;
		tick(1);
		cfgWrite = 0;
		tick(1);
	endtask
	task acc(input w, input [7:0] mk, input [7:0] d);
		dataWrite = w;
		dataRead = !w;
		dataAddrMask = mk;
		dataWrData = d;
		tick(1);
		dataWrite = 0;
		dataRead = 0;
		tick(1);
	endtask
	task clr(input [7:0] bits);
		irqClearBits = bits;
		tick(1);
		irqClearBits = 0;
		tick(1);
	endtask
	task rst_chk;
		for (s = 0; s < 14; s = s + 1)
			check("reset value", cfgView[s*8 +: 8], RST_VIEW[s*8 +: 8]);
		check("reset enable", padOeN_reg, 8'hFF);
		check("debug alt", dbgAltSelect, DBG_ALT_RST);
	endtask
	// a earlier sample, b later sample, per pin trigger
	function [7:0] trig(input [2:0] mode, input [7:0] x, input [7:0] y);
		if (mode[2]) trig = mode[0] ? x | y : ~x | ~y;
		else if (mode[1]) trig = x ^ y;
		else trig = mode[0] ? ~x & y : x & ~y;
	endfunction
	task finish_test;
		if (errors == 0 && nTests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		i = $urandom(89647);
		tick(12);
		rst_chk;
		arst_n = 1;
		extLevel = $urandom;
		tick(4);
		acc(0, 8'hFF, 8'h00);
		check("input read", dataRdData_reg, extLevel);
		check("absent input", dbgRdData, extLevel & DBG_PRESENT);
		cfg(`CFG_DIRECTION, 8'hFF);
		exp = 8'hA5;
		acc(1, 8'hFF, exp);
		acc(1, 8'h00, 8'h5A);
		check("pad enable", padOeN_reg, 8'h00);
		for (i = 0; i < 8; i = i + 1) begin
			m = $urandom;
			dataWrData = $urandom;
			exp = exp & ~m | dataWrData & m;
			acc(1, m, dataWrData);
			check("pad out", padOut_reg, exp);
			m = $urandom;
			acc(0, m, 8'h00);
			check("read", dataRdData_reg, exp & m);
			check("absent read", dbgRdData, exp & m & DBG_PRESENT);
		end
		cfg(`CFG_DIRECTION, 8'h00);
		for (i = 0; i < 5; i = i + 1) begin
			md = MODES[i*3 +: 3];
			cfg(`CFG_IRQ_MASK, 8'h00);
			cfg(`CFG_IRQ_SENSE, {8{md[2]}});
			cfg(`CFG_IRQ_BOTH, {8{md[1]}});
			cfg(`CFG_IRQ_EVENT, {8{md[0]}});
			a = $urandom;
			b = $urandom;
			extLevel = a;
			tick(5);
			clr(8'hFF);
			extLevel = b;
			tick(5);
			exp = trig(md, a, b);
			check("raw", irqRawStatus_reg, exp);
			check("masked off", irqMaskedStatus_reg, 8'h00);
			cfg(`CFG_IRQ_MASK, 8'hFF);
			check("masked", irqMaskedStatus_reg, exp);
			check("port irq", irqOut_reg, |exp);
			c = $urandom;
			clr(c);
			check("cleared", irqRawStatus_reg, exp & ~c | trig(md, b, b));
		end
		cfg(`CFG_DIRECTION, 8'hFF);
		cfg(`CFG_ALT_FUNC, 8'hFF);
		altOut = $urandom;
		altOe = $urandom;
		extLevel = $urandom;
		tick(4);
		check("alt enable", padOeN_reg, ~altOe);
		check("alt out", padOut_reg & altOe, altOut & altOe);
		check("alt in", altIn_reg, altOe & altOut | ~altOe & extLevel);
		cfg(`CFG_ALT_FUNC, 8'h00);
		check("soft enable", padOeN_reg, 8'h00);
		for (s = 0; s < 14; s = s + 1) begin
			m = $urandom;
			cfg(s, m);
			check("config", cfgView[s*8 +: 8], m);
		end
		for (s = 0; s < 16; s = s + 1) begin
			identIndex = s;
			tick(1);
			exp = (s < `ID_COUNT) ? ID_VIEW[s*8 +: 8] : 8'h00;
			check("ident", identWord_reg, exp);
		end
		arst_n = 0;
		tick(1);
		rst_chk;
		arst_n = 1;
		tick(2);
		finish_test;
	end
endmodule // general_purpose_io_port_bench

// File: test/general_purpose_io_port_properties.sv
`timescale 1ns/10ps
`include "gpio_port_defines.vh"
module gpio_port_checker #(
	parameter [7:0] PIN_PRESENT = `ALL_PINS
) (
	// clock and reset
	input wire       clk,
	input wire       arst_n,
	// requests
	input wire       dataRead,
	input wire [7:0] dataAddrMask,
	input wire       cfgWrite,
	input wire [3:0] cfgSelect,
	input wire [7:0] cfgWrData,
	input wire [7:0] irqClearBits,
	input wire [3:0] identIndex,
	// results
	input wire [7:0] dataRdData_reg,
	input wire [7:0] irqRawStatus_reg,
	input wire [7:0] irqMaskedStatus_reg,
	input wire       irqOut_reg,
	input wire [7:0] pinDirectionBits_reg,
	input wire [7:0] irqMaskBits_reg,
	input wire [7:0] identWord_reg
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_merge; irqOut_reg == |irqMaskedStatus_reg; endproperty
	a_merge: assert property (p_merge)
		else $error("port interrupt differs from masked status");
	property p_subset; (irqMaskedStatus_reg & ~irqRawStatus_reg) == 0; endproperty
	a_subset: assert property (p_subset)
		else $error("masked bit without raw bit");
	property p_sticky;
		(~irqRawStatus_reg & $past(irqRawStatus_reg) & ~$past(irqClearBits)) == 0;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("raw bit dropped without clear");
	property p_dir; cfgWrite && cfgSelect == `CFG_DIRECTION
		|=> pinDirectionBits_reg == ($past(cfgWrData) & PIN_PRESENT);
	endproperty
	a_dir: assert property (p_dir)
		else $error("direction write lost");
	property p_mask; cfgWrite && cfgSelect == `CFG_IRQ_MASK
		|=> irqMaskBits_reg == ($past(cfgWrData) & PIN_PRESENT); endproperty
	a_mask: assert property (p_mask)
		else $error("mask write lost");
	property p_rdmask; dataRead |=> (dataRdData_reg & ~$past(dataAddrMask)) == 0;
	endproperty
	a_rdmask: assert property (p_rdmask)
		else $error("masked read bit not zero");
	property p_rdhold; !dataRead |=> $stable(dataRdData_reg); endproperty
	a_rdhold: assert property (p_rdhold)
		else $error("read data moved without read");
	property p_ident; identIndex > 4'hB |=> identWord_reg == 8'h00; endproperty
	a_ident: assert property (p_ident)
		else $error("ident word beyond range not zero");
	c_irq: cover property ($rose(irqOut_reg));
	c_read: cover property (dataRead);
	c_clear: cover property (|(irqClearBits & irqRawStatus_reg));
endmodule // gpio_port_checker
bind general_purpose_io_port gpio_port_checker
	#(.PIN_PRESENT(PIN_PRESENT)) i_chk (.*);

// File: test/pad_model.sv
`timescale 1ns/10ps
module pad_model (
	// port side
	input  wire [7:0] padOut,
	input  wire [7:0] padOeN,
	// outside world, holds its level until told otherwise
	input  wire [7:0] extLevel,
	output wire [7:0] padIn
);
	// driven pins loop back, others follow the outside level
	assign padIn = ~padOeN & padOut | padOeN & extLevel;
endmodule // pad_model
